// *** inc/ds3_rx_frame_pkg.sv ***
// constants shared by the ds3 receive framer control/status block
// assumes one 100 MHz clock and an axi4-lite register bus
package ds3_rx_frame_pkg;
    // ============================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TEST = 8'h0C;
    localparam logic [7:0] IDX_CFG = 8'h10;
    localparam logic [7:0] IDX_FAR = 8'h11;
    localparam logic [7:0] IDX_RXINT = 8'h13;
    localparam logic [7:0] IDX_MODE = 8'h1F;
    localparam logic [7:0] IDX_REG51 = 8'h51;
    // ============================================================
    // field positions
    localparam int CFG_AIS = 7;
    localparam int CFG_LOS = 6;
    localparam int CFG_IDLE = 5;
    localparam int CFG_OOF = 4;
    localparam int CFG_PAR = 2;
    localparam int CFG_FSEL = 1;
    localparam int CFG_MSEL = 0;
    localparam int TST_OHSRC = 7;
    localparam int TST_RXPCLK = 6;
    localparam int TST_TXPCLK = 5;
    localparam int TST_LOCK = 4;
    localparam int TST_CHK = 3;
    localparam int TST_GEN = 2;
    localparam int FAR_FERF = 5;
    localparam int FAR_AIC = 4;
    // ============================================================
    // values after reset and mode-dependent defaults
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [7:0] FAR_RST = 8'h10;
    localparam logic [7:0] RXINT_CBIT = 8'h40;
    localparam logic [7:0] RXINT_M13 = 8'h00;
    localparam logic [7:0] REG51_M13 = 8'h6E;
    localparam logic [2:0] FEBE_CLEAN = 3'h7;
    localparam logic [2:0] FEBE_ERRED = 3'h3;
    // ============================================================
    // framing windows and thresholds
    localparam int F_WIN = 16;
    localparam logic [4:0] F_TH_STRICT = 5'h03;
    localparam logic [4:0] F_TH_LOOSE = 5'h06;
    localparam int M_WIN = 4;
    localparam logic [2:0] M_TH = 3'h3;
    localparam int P_WIN = 5;
    localparam logic [2:0] P_TH = 3'h2;
    localparam logic [5:0] AIC_SET_FRAMES = 6'h3F;
    localparam int AIC_HIST = 15;
    localparam logic [3:0] AIC_CLR_ZEROS = 4'h2;
    localparam logic [4:0] LOCK_MATCHES = 5'h10;
    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TX_BIT_NS = 40;
    localparam int TX_BIT_CYCLES = (TX_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_INFRAME = 2'b01, ST_SEARCH = 2'b10} frame_state_t;
endpackage

// *** rtl/ds3_rx_frame_maint_status.sv ***
// ds3 receive framer control and status with test-register controls
// assumes framer datapath events arrive as one-cycle pulses on aclk
// ============================================================
// Summary of operation
// - mode 0: pin pulses before each overhead bit
// - mode 1: pin is gapped payload clock
// - lock flag reports checker pattern synchronisation
// - checker enable bit turns checker on/off
// - generator enable bit turns generator on/off
// - defaults differ for m13 mode registers
// - alarm pattern flag follows ais detection
// - signal loss flag follows los detection
// - idle flag follows idle pattern detection
// - out-of-frame flag follows framer state
// - parity select adds p-bit check to acquisition
// - parity select: 2 of 5 errors reframes
// - f-bit errors 3 or 6 of 16
// - m-bit errors 3 of 4 or ignored
// - far-end status register layout
// - aic set after 63 ones, cleared by zeros
// - febe code from latest frame
//
// Added by the designer: register access over AXI4-Lite.
module ds3_rx_frame_maint_status import ds3_rx_frame_pkg::*; #(
    parameter int BIT_CYCLES = TX_BIT_CYCLES,
    parameter logic [7:0] REG51_CBIT = 8'h00
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ais_detect,
    input wire logic los_detect,
    input wire logic idle_detect,
    input wire logic ferf_detect,
    input wire logic f_bit_valid,
    input wire logic f_bit_error,
    input wire logic m_bit_valid,
    input wire logic m_bit_error,
    input wire logic p_check_valid,
    input wire logic p_bit_error,
    input wire logic acq_fm_found,
    input wire logic acq_parity_ok,
    input wire logic frame_end,
    input wire logic aic_bit,
    input wire logic [2:0] febe_value,
    input wire logic rx_payload_valid,
    input wire logic rx_payload_bit,
    input wire logic tx_overhead_next,
    input wire logic tx_serial_payload_in,
    output logic tx_overhead_marker_pin,
    output logic tx_payload_valid,
    output logic tx_payload_bit,
    output logic rx_gapped_clock_sel,
    output logic tx_overhead_from_serial,
    output logic m13_mode
);
    // ============================================================
    // register state
    logic [2:0] cfg_r;
    logic [7:0] test_r;
    logic mode_r;
    logic [7:0] far_r;
    frame_state_t state_r, state_nxt;
    logic aw_got_r, w_got_r;
    logic [7:0] aw_idx_r;
    logic [7:0] wdata_r;
    logic wstrb_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    function automatic logic [7:0] idx_of(input logic [11:0] addr);
        return addr[9:2];
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        return idx == IDX_TEST || idx == IDX_CFG || idx == IDX_FAR ||
               idx == IDX_RXINT || idx == IDX_MODE || idx == IDX_REG51;
    endfunction

    // ============================================================
    // axi4-lite write path: address and data taken in either order
    wire logic do_write = aw_got_r && w_got_r && !bvalid_r;
    wire logic wr_hit = do_write && wstrb_r;
    wire logic wr_cfg = wr_hit && aw_idx_r == IDX_CFG;
    wire logic wr_test = wr_hit && aw_idx_r == IDX_TEST;
    wire logic wr_mode = wr_hit && aw_idx_r == IDX_MODE;
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_idx_r <= 8'h00;
            wdata_r <= 8'h00;
            wstrb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_idx_r <= idx_of(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata[7:0];
                wstrb_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // writable fields; read-only and reserved bits drop writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= CFG_RST[2:0];
            test_r <= TEST_RST;
            mode_r <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_r <= wdata_r[2:0];
            end
            if (wr_test) begin
                test_r <= {wdata_r[7:5], 1'b0, wdata_r[3:2], 2'b00};
            end
            if (wr_mode) begin
                mode_r <= wdata_r[0];
            end
        end
    end

    wire logic par_sel = cfg_r[CFG_PAR];
    wire logic f_sel = cfg_r[CFG_FSEL];
    wire logic m_sel = cfg_r[CFG_MSEL];
    wire logic chk_en = test_r[TST_CHK];
    wire logic gen_en = test_r[TST_GEN];
    wire logic pclk_mode = test_r[TST_TXPCLK];
    assign rx_gapped_clock_sel = test_r[TST_RXPCLK];
    assign tx_overhead_from_serial = test_r[TST_OHSRC];
    assign m13_mode = mode_r;

    // ============================================================
    // frame maintenance windows
    logic [4:0] f_cnt;
    logic [2:0] m_cnt;
    logic [2:0] p_cnt;
    wire logic searching = state_r == ST_SEARCH;

    err_window #(.DEPTH(F_WIN), .CW(5)) u_f_win (
        .aclk(aclk), .aresetn(aresetn), .clear(searching),
        .valid(f_bit_valid), .err(f_bit_error), .count(f_cnt)
    );
    err_window #(.DEPTH(M_WIN), .CW(3)) u_m_win (
        .aclk(aclk), .aresetn(aresetn), .clear(searching),
        .valid(m_bit_valid), .err(m_bit_error), .count(m_cnt)
    );
    err_window #(.DEPTH(P_WIN), .CW(3)) u_p_win (
        .aclk(aclk), .aresetn(aresetn), .clear(searching),
        .valid(p_check_valid), .err(p_bit_error), .count(p_cnt)
    );

    wire logic [4:0] f_th = f_sel ? F_TH_STRICT : F_TH_LOOSE;
    wire logic f_fail = f_cnt >= f_th;
    wire logic m_fail = m_sel && m_cnt >= M_TH;
    wire logic p_fail = par_sel && p_cnt >= P_TH;
    wire logic acq_ok = acq_fm_found && (!par_sel || acq_parity_ok);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_INFRAME: begin
                if (f_fail || m_fail || p_fail) begin
                    state_nxt = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (acq_ok) begin
                    state_nxt = ST_INFRAME;
                end
            end
            default: state_nxt = ST_SEARCH;
        endcase
    end

    // starts in frame so the status reads its documented zero after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_INFRAME;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ============================================================
    // far-end indications
    logic [5:0] aic_run_r;
    logic [AIC_HIST-1:0] aic_hist_r;
    logic [3:0] aic_zeros;
    always_comb begin
        aic_zeros = 4'h0;
        for (int i = 0; i < AIC_HIST; i++) begin
            aic_zeros = aic_zeros + {3'b000, !aic_hist_r[i]};
        end
    end
    wire logic [AIC_HIST-1:0] aic_hist_nxt = {aic_hist_r[AIC_HIST-2:0], aic_bit};
    wire logic aic_set = frame_end && aic_bit && aic_run_r >= AIC_SET_FRAMES - 6'h01;

    // history starts all ones, so a single zero after reset keeps the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            far_r <= mode_r ? 8'h00 : FAR_RST;
            aic_run_r <= 6'h00;
            aic_hist_r <= '1;
        end else begin
            far_r[7:6] <= 2'b00;
            far_r[3] <= 1'b0;
            far_r[FAR_FERF] <= ferf_detect;
            if (frame_end) begin
                far_r[2:0] <= febe_value;
                aic_hist_r <= aic_hist_nxt;
                aic_run_r <= !aic_bit ? 6'h00 : (aic_run_r == AIC_SET_FRAMES) ? aic_run_r :
                             aic_run_r + 6'h01;
                if (aic_set) begin
                    far_r[FAR_AIC] <= 1'b1;
                end else if (aic_zeros >= AIC_CLR_ZEROS ||
                             (!aic_bit && aic_zeros >= AIC_CLR_ZEROS - 4'h1)) begin
                    far_r[FAR_AIC] <= 1'b0;
                end
            end
            if (wr_mode && wdata_r[0] != mode_r) begin
                far_r[FAR_AIC] <= !wdata_r[0];
            end
        end
    end

    // ============================================================
    // transmit overhead marker / gapped payload clock
    logic [7:0] bit_cnt_r;
    logic oh_mark_r, oh_proc_r, pin_r;
    logic txv_r, txb_r;
    wire logic bit_tick = bit_cnt_r == 8'(BIT_CYCLES - 1);
    wire logic first_half = bit_cnt_r < 8'(BIT_CYCLES / 2);
    wire logic pin_nxt = pclk_mode ? (first_half && !oh_proc_r) : oh_mark_r;
    wire logic gen_bit;
    wire logic gen_tick = bit_tick && !oh_proc_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt_r <= 8'h00;
            oh_mark_r <= 1'b0;
            oh_proc_r <= 1'b0;
            pin_r <= 1'b0;
            txv_r <= 1'b0;
            txb_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_tick ? 8'h00 : bit_cnt_r + 8'h01;
            pin_r <= pin_nxt;
            txv_r <= gen_tick;
            if (bit_tick) begin
                oh_mark_r <= tx_overhead_next;
                oh_proc_r <= oh_mark_r;
            end
            // sampled at the period end, one clock (a quarter period) after the falling edge
            if (gen_tick) begin
                txb_r <= gen_en ? gen_bit : tx_serial_payload_in;
            end
        end
    end
    assign tx_overhead_marker_pin = pin_r;
    assign tx_payload_valid = txv_r;
    assign tx_payload_bit = txb_r;

    // ============================================================
    // pattern generator and checker
    logic lock_raw;
    prbs_unit u_prbs (
        .aclk(aclk), .aresetn(aresetn),
        .gen_en(gen_en), .gen_tick(gen_tick), .gen_bit(gen_bit),
        .chk_en(chk_en), .chk_valid(rx_payload_valid), .chk_bit(rx_payload_bit),
        .lock(lock_raw)
    );

    // ============================================================
    // read path; reserved bit 3 of the config register reads zero
    wire logic [7:0] ar_idx = idx_of(s_axi_araddr);
    wire logic [7:0] cfg_rd = {ais_detect, los_detect, idle_detect, searching, 1'b0, cfg_r};
    wire logic [7:0] test_rd = {test_r[7:5], lock_raw, test_r[3:2], 2'b00};
    wire logic [7:0] rd_byte =
        (ar_idx == IDX_CFG) ? cfg_rd :
        (ar_idx == IDX_FAR) ? far_r :
        (ar_idx == IDX_TEST) ? test_rd :
        (ar_idx == IDX_RXINT) ? (mode_r ? RXINT_M13 : RXINT_CBIT) :
        (ar_idx == IDX_REG51) ? (mode_r ? REG51_M13 : REG51_CBIT) :
        (ar_idx == IDX_MODE) ? {7'h00, mode_r} : 8'h00;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ============================================================
    // assertions
    AST_F_STRICT: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_INFRAME && f_sel && f_cnt >= 5'h03 |=> state_r == ST_SEARCH)
        else $error("f-bit 3 of 16 did not declare oof");
    AST_F_LOOSE: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_INFRAME && !f_sel && f_cnt < 5'h06 && !m_fail && !p_fail
        |=> state_r == ST_INFRAME)
        else $error("oof declared below 6 of 16 f-bit errors");
    AST_M_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_INFRAME && !m_sel && !f_fail && !p_fail |=> state_r == ST_INFRAME)
        else $error("m-bit errors caused oof while ignored");
    AST_M_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_INFRAME && m_sel && m_cnt >= 3'h3 |=> searching)
        else $error("m-bit 3 of 4 did not declare oof");
    AST_P_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_INFRAME && par_sel && p_cnt >= 3'h2 |=> searching)
        else $error("p-bit 2 of 5 did not start a search");
    AST_ACQ_PARITY: assert property (@(posedge aclk) disable iff (!aresetn)
        searching && par_sel && !acq_parity_ok |=> searching)
        else $error("in-frame without parity");
    AST_OOF_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && ar_idx == IDX_CFG
        |=> s_axi_rdata[CFG_OOF] == $past(searching) && s_axi_rdata[3] == 1'b0)
        else $error("oof flag readback wrong");
    AST_FEBE: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_end |=> far_r[2:0] == $past(febe_value))
        else $error("febe not loaded");
    AST_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
        pclk_mode && oh_proc_r && $past(pclk_mode) && $past(oh_proc_r) |=> !pin_r)
        else $error("gapped clock edge during overhead bit");
    AST_MARK: assert property (@(posedge aclk) disable iff (!aresetn)
        !pclk_mode |=> pin_r == $past(oh_mark_r))
        else $error("overhead marker does not track pending overhead");
    AST_LOCK_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !chk_en |=> !lock_raw)
        else $error("lock reported with checker off");
    AST_WR_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid && ((s_axi_bresp == RESP_SLVERR) == !mapped(aw_idx_r)))
        else $error("write response wrong");

    COV_OOF: cover property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_INFRAME ##1 state_r == ST_SEARCH);
    COV_REACQ: cover property (@(posedge aclk) disable iff (!aresetn)
        searching ##1 state_r == ST_INFRAME);
    COV_LOCK: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lock_raw));
    COV_AIC: cover property (@(posedge aclk) disable iff (!aresetn) $fell(far_r[FAR_AIC]));
endmodule

// *** rtl/err_window.sv ***
// sliding-window error counter over the last DEPTH checked bits
// assumes valid marks one checked bit; clear empties the window
module err_window import ds3_rx_frame_pkg::*; #(
    parameter int DEPTH = 16,
    parameter int CW = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic valid,
    input wire logic err,
    output logic [CW-1:0] count
);
    logic [DEPTH-1:0] hist_r;
    logic [CW-1:0] count_r;
    wire logic [CW-1:0] in_w = {{(CW-1){1'b0}}, err};
    wire logic [CW-1:0] out_w = {{(CW-1){1'b0}}, hist_r[DEPTH-1]};
    wire logic [CW-1:0] count_nxt = CW'(count_r + in_w - out_w);

    // ============================================================
    // window update
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            hist_r <= '0;
            count_r <= '0;
        end else if (valid) begin
            hist_r <= {hist_r[DEPTH-2:0], err};
            count_r <= count_nxt;
        end
    end
    assign count = count_r;
endmodule

// *** rtl/prbs_unit.sv ***
// pattern generator and self-synchronising checker, x^15 + x^14 + 1
// assumes ticks and valids are one-cycle pulses at the bit rate
module prbs_unit import ds3_rx_frame_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic gen_en,
    input wire logic gen_tick,
    output logic gen_bit,
    input wire logic chk_en,
    input wire logic chk_valid,
    input wire logic chk_bit,
    output logic lock
);
    logic [14:0] gen_r;
    logic [14:0] chk_r;
    logic [4:0] match_r;
    logic lock_r;
    wire logic gen_fb = gen_r[14] ^ gen_r[13];
    wire logic chk_match = (chk_r[14] ^ chk_r[13]) == chk_bit;

    // ============================================================
    // generator; never seeded all-zero
    always_ff @(posedge aclk) begin
        if (!aresetn || !gen_en) begin
            gen_r <= 15'h7FFF;
        end else if (gen_tick) begin
            gen_r <= {gen_r[13:0], gen_fb};
        end
    end
    assign gen_bit = gen_r[14];

    // ============================================================
    // checker: one mismatch drops lock, a run of matches takes it
    always_ff @(posedge aclk) begin
        if (!aresetn || !chk_en) begin
            chk_r <= '0;
            match_r <= '0;
            lock_r <= 1'b0;
        end else if (chk_valid) begin
            chk_r <= {chk_r[13:0], chk_bit};
            match_r <= !chk_match ? 5'h00 : (match_r == LOCK_MATCHES) ? match_r : match_r + 5'h01;
            lock_r <= chk_match && (lock_r || match_r == LOCK_MATCHES - 5'h01);
        end
    end
    assign lock = lock_r;
endmodule

// *** testbench/ds3_far_side.sv ***
// far side: overhead timing source, terminal payload source, payload loopback
// assumes pin is the gapped payload clock when the payload clock mode is on
module ds3_far_side (
    input wire logic aclk,
    input wire logic pin,
    input wire logic tx_valid,
    input wire logic tx_bit,
    output logic oh_next,
    output logic ser_in,
    output logic rx_valid,
    output logic rx_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt = '0;
    initial {oh_next, ser_in, rx_valid, rx_bit} = '0;
    // ====
    // loopback feeds the checker, so lock follows the generator
    always @(posedge aclk) begin
        cnt <= cnt + 5'h01;
        oh_next <= &cnt[4:2];
        rx_valid <= tx_valid;
        rx_bit <= tx_bit;
    end
    always @(negedge pin) ser_in <= 1'($urandom());
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the ds3 receive framer control/status block
// assumes the package and the far-side model are compiled first
module testbench import ds3_rx_frame_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = '0, aresetn = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ais_detect = '0, los_detect = '0, idle_detect = '0, ferf_detect = '0;
    logic f_bit_valid = '0, f_bit_error = '0, m_bit_valid = '0, m_bit_error = '0;
    logic p_check_valid = '0, p_bit_error = '0, acq_fm_found = '0, acq_parity_ok = '0;
    logic frame_end = '0, aic_bit = 1'h1;
    logic [2:0] febe_value = '0, v;
    logic rx_payload_valid, rx_payload_bit, tx_overhead_next, tx_serial_payload_in;
    logic tx_overhead_marker_pin, tx_payload_valid, tx_payload_bit;
    logic rx_gapped_clock_sel, tx_overhead_from_serial, m13_mode;
    int err_total = 0;
    int tests_run = 0;
    logic ser_chk = 1'b0;
    logic [33:0] exp_q[$];
    ds3_rx_frame_maint_status DUT (.*);
    ds3_far_side far (.aclk(aclk), .pin(tx_overhead_marker_pin), .tx_valid(tx_payload_valid),
        .tx_bit(tx_payload_bit), .oh_next(tx_overhead_next), .ser_in(tx_serial_payload_in),
        .rx_valid(rx_payload_valid), .rx_bit(rx_payload_bit));
    always #5 aclk = ~aclk;
    // ====
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t read %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // both channels are idle-ready here, so they are taken at one edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'($urandom()), d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [9:0] e);
        exp_q.push_back({e[9:8], 24'h0, e[7:0]});
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask
    // k: 0 f-bit, 1 m-bit, 2 p-check, 3 acquisition found, 4 frame end
    task automatic hit(input int k, input int n, input logic e);
        f_bit_error <= e;
        m_bit_error <= e;
        p_bit_error <= e;
        repeat (n) begin
            {f_bit_valid, m_bit_valid, p_check_valid} <= {k == 0, k == 1, k == 2};
            {acq_fm_found, frame_end} <= {k == 3, k == 4};
            @(posedge aclk);
            {f_bit_valid, m_bit_valid, p_check_valid, acq_fm_found, frame_end} <= '0;
            @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask
    // clean bits afterwards flush every window before the next case
    task automatic oof_case(input logic [7:0] c, input int k, input int n, input logic o);
        wr(IDX_CFG, c);
        hit(k, n, 1'h1);
        rd(IDX_CFG, {2'h0, c | {3'h0, o, 4'h0}});
        acq_parity_ok <= 1'h0;
        hit(3, 1, 1'h0);
        rd(IDX_CFG, {2'h0, c | {3'h0, o & c[CFG_PAR], 4'h0}});
        acq_parity_ok <= 1'h1;
        hit(3, 1, 1'h0);
        hit(0, 16, 1'h0);
        hit(1, 4, 1'h0);
        hit(2, 5, 1'h0);
    endtask
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    // terminal bit changes only at the gapped clock's fall, so it still stands here
    always @(posedge aclk) begin
        if (ser_chk && tx_payload_valid) chk({33'h0, tx_payload_bit}, {33'h0, tx_serial_payload_in});
    end
    // ====
    initial begin
        void'($urandom(32'h483B527B));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(IDX_CFG, {2'h0, CFG_RST});
        rd(IDX_FAR, {2'h0, FAR_RST});
        rd(IDX_TEST, {2'h0, TEST_RST});
        rd(8'hFC, {RESP_SLVERR, 8'h00});
        repeat (4) begin
            v = 3'($urandom());
            {ais_detect, los_detect, idle_detect} <= v;
            rd(IDX_CFG, {2'h0, v, 5'h00});
        end
        {ais_detect, los_detect, idle_detect} <= '0;
        wr(IDX_CFG, 8'hFF);
        rd(IDX_CFG, 10'h007);
        oof_case(8'h02, 0, 3, 1'h1);
        oof_case(8'h00, 0, 5, 1'h0);
        oof_case(8'h00, 0, 6, 1'h1);
        oof_case(8'h00, 1, 3, 1'h0);
        oof_case(8'h01, 1, 3, 1'h1);
        oof_case(8'h00, 2, 2, 1'h0);
        oof_case(8'h04, 2, 2, 1'h1);
        v = 3'($urandom());
        ferf_detect <= 1'h1;
        febe_value <= v;
        hit(4, 1, 1'h0);
        rd(IDX_FAR, {5'h06, v});
        aic_bit <= 1'h0;
        hit(4, 2, 1'h0);
        rd(IDX_FAR, {5'h04, v});
        wr(IDX_MODE, 8'h01);
        rd(IDX_RXINT, {2'h0, RXINT_M13});
        rd(IDX_REG51, {2'h0, REG51_M13});
        wr(IDX_TEST, 8'h0C);
        repeat (400) @(posedge aclk);
        rd(IDX_TEST, 10'h01C);
        wr(IDX_TEST, 8'h2C);
        repeat (400) @(posedge aclk);
        rd(IDX_TEST, 10'h03C);
        wr(IDX_TEST, 8'h24);
        rd(IDX_TEST, 10'h024);
        wr(IDX_TEST, 8'hE0);
        chk({31'h0, rx_gapped_clock_sel, tx_overhead_from_serial, m13_mode}, 34'h7);
        repeat (8) @(posedge aclk);
        ser_chk <= 1'b1;
        repeat (200) @(posedge aclk);
        ser_chk <= 1'b0;
        @(posedge aclk);
        end_of_test();
    end
    initial begin
        #100us;
        err_total++;
        end_of_test();
    end
endmodule
